/* logic/rbm_pkg.sv */
// Constants and types shared by the reset, boot and pin selector block
package rbm_pkg;
    // Cycle counts on the low-frequency clock
    localparam int QUAL_CYC = 3;
    localparam int STRETCH_CYC = 7;
    localparam int BOOT_LEAD_CYC = 3;
    localparam int CNT_W = 3;

    // Multiplexed pin positions in the pad vectors
    localparam int NPINS = 8;
    localparam int PIN_IRQ6 = 0;
    localparam int PIN_IRQ7 = 1;
    localparam int PIN_KEY_ROW_6 = 2;
    localparam int PIN_KEY_ROW_7 = 3;
    localparam int PIN_TXD = 4;
    localparam int PIN_RXD = 5;
    localparam int PIN_CTS = 6;
    localparam int PIN_RTS = 7;
    localparam int NAUDIO = 4;

    // Reset values
    localparam logic RST_BOOT_ROM = 1'b0;
    localparam logic RST_STO_LEVEL = 1'b0;
    localparam logic RST_SYNC_LEVEL = 1'b1;

    typedef enum logic [1:0] {
        RBM_IDLE,
        RBM_HOLD,
        RBM_STRETCH
    } rbm_state_type;
endpackage

/* logic/rbm_req_qual.sv */
// Synchroniser and low-level qualifier for one reset request pin
`timescale 1ns/1ps
`default_nettype none
module rbm_req_qual #(
    parameter int QUAL = rbm_pkg::QUAL_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic req_n,
    output logic valid
);
    initial begin
        if (QUAL < 1 || QUAL > 7) begin
            $error("rbm_req_qual: QUAL out of range");
        end
    end

    localparam logic [2:0] QUAL_C = 3'(QUAL);

    logic s1_r;
    logic s2_r;
    logic [2:0] cnt_r;

    // Two-flop synchroniser; first stage read only by the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_r <= rbm_pkg::RST_SYNC_LEVEL;
            s2_r <= rbm_pkg::RST_SYNC_LEVEL;
        end else begin
            s1_r <= req_n;
            s2_r <= s1_r;
        end
    end

    // Consecutive low samples, saturating at the qualify count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 3'h0;
        end else if (s2_r) begin
            cnt_r <= 3'h0;
        end else if (cnt_r != QUAL_C) begin
            cnt_r <= cnt_r + 3'h1;
        end
    end

    assign valid = (cnt_r == QUAL_C);

    qual_needs_low_a: assert property (@(posedge clk) disable iff (!rstn)
        valid |-> !$past(s2_r) && !$past(s2_r, 2) && !$past(s2_r, 3))
        else $error("request qualified after fewer than three low samples");

    qual_fires_a: assert property (@(posedge clk) disable iff (!rstn)
        (!s2_r) [*3] |=> valid)
        else $error("three low samples did not qualify the request");
endmodule
`default_nettype wire

/* logic/rbm_top.sv */
// Reset qualification and stretching, boot capture and alternate pin routing
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Request valid after three low clock cycles
// - Reset output low at least seven cycles
// - Alternate request pin qualifies like primary
// - Watchdog expiry starts a stretched reset
// - Output asserts at once, holds with request
// - Seven more low cycles after request release
// - Capture boot select three cycles before release
// - Captured high boots ROM, low boots flash
// - Alternate select turns RTS into request
// - Alternate select swaps five pins to test
// - Alternate test pins disconnect primary ones
// - Test reset reaches controller without clocking
// - Alternate debug pins disable primary ones
// - Muxed pins stay inputs in reset unless alternate select is on
// - Audio on muxed pin disables primary while alternate select is off
// - Soft turn off level survives reset sequence
module rbm_top #(
    parameter int STRETCH = rbm_pkg::STRETCH_CYC,
    parameter int BOOT_LEAD = rbm_pkg::BOOT_LEAD_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reset_in_n,
    input wire logic watchdog_expired,
    input wire logic boot_select,
    input wire logic alt_pin_select,
    output logic reset_out_n,
    output logic boot_from_rom,
    output logic boot_from_flash,
    input wire logic sto_we,
    input wire logic sto_level,
    output logic soft_turn_off_out,
    input wire logic [rbm_pkg::NPINS-1:0] pad_in,
    output logic [rbm_pkg::NPINS-1:0] pad_out,
    output logic [rbm_pkg::NPINS-1:0] pad_oe_n,
    input wire logic [rbm_pkg::NPINS-1:0] periph_out,
    input wire logic [rbm_pkg::NPINS-1:0] periph_oe,
    input wire logic [rbm_pkg::NAUDIO-1:0] audio_sel,
    output logic [rbm_pkg::NPINS-1:0] periph_in,
    output logic [rbm_pkg::NAUDIO-1:0] audio_pri_disable,
    input wire logic pri_trst_n,
    input wire logic pri_tms,
    input wire logic pri_tck,
    input wire logic pri_tdi,
    input wire logic tap_tdo,
    input wire logic tap_tdo_en,
    output logic tap_trst_n,
    output logic tap_tms,
    output logic tap_tck,
    output logic tap_tdi,
    output logic pri_tdo_out,
    output logic pri_tdo_oe_n,
    input wire logic dsp_debug_event_out,
    input wire logic dsp_debug_event_oe,
    input wire logic mcu_debug_event_out,
    input wire logic mcu_debug_event_oe,
    output logic dsp_debug_event,
    output logic mcu_debug_event,
    output logic pri_debug_disable
);
    initial begin
        if (STRETCH < 2 || STRETCH > 7) begin
            $error("rbm_top: STRETCH out of range");
        end
        if (BOOT_LEAD < 1 || BOOT_LEAD >= STRETCH) begin
            $error("rbm_top: BOOT_LEAD must be below STRETCH");
        end
    end

    localparam logic [rbm_pkg::CNT_W-1:0] STRETCH_LAST = rbm_pkg::CNT_W'(STRETCH - 1);
    localparam logic [rbm_pkg::CNT_W-1:0] BOOT_AT = rbm_pkg::CNT_W'(STRETCH - 1 - BOOT_LEAD);

    rbm_pkg::rbm_state_type state_r;
    rbm_pkg::rbm_state_type state_nxt;
    logic [rbm_pkg::CNT_W-1:0] cnt_r;
    logic reset_out_n_r;
    logic boot_r;
    logic sto_r;
    logic pri_req_n;
    logic alt_req_n;
    logic pri_valid;
    logic alt_valid;
    logic req_any;
    logic alt;

    assign alt = alt_pin_select;

    // Primary request is ignored while RTS carries it instead
    assign pri_req_n = alt ? 1'b1 : reset_in_n;
    assign alt_req_n = alt ? pad_in[rbm_pkg::PIN_RTS] : 1'b1;

    rbm_req_qual #(
        .QUAL(rbm_pkg::QUAL_CYC)
    ) u_qual_pri (
        .clk(clk),
        .rstn(rstn),
        .req_n(pri_req_n),
        .valid(pri_valid)
    );

    rbm_req_qual #(
        .QUAL(rbm_pkg::QUAL_CYC)
    ) u_qual_alt (
        .clk(clk),
        .rstn(rstn),
        .req_n(alt_req_n),
        .valid(alt_valid)
    );

    assign req_any = pri_valid | alt_valid;

    // Sequencer: hold while requested, then stretch
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            rbm_pkg::RBM_IDLE: begin
                if (req_any) begin
                    state_nxt = rbm_pkg::RBM_HOLD;
                end else if (watchdog_expired) begin
                    state_nxt = rbm_pkg::RBM_STRETCH;
                end
            end
            rbm_pkg::RBM_HOLD: begin
                if (!req_any) begin
                    state_nxt = rbm_pkg::RBM_STRETCH;
                end
            end
            rbm_pkg::RBM_STRETCH: begin
                if (req_any) begin
                    state_nxt = rbm_pkg::RBM_HOLD;
                end else if (cnt_r == STRETCH_LAST && !watchdog_expired) begin
                    state_nxt = rbm_pkg::RBM_IDLE;
                end
            end
        endcase
    end

    // Power-on reset starts in the stretch so the output is also stretched
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_r <= rbm_pkg::RBM_STRETCH;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Stretch counter restarts on each entry and on a new watchdog expiry
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (state_r != rbm_pkg::RBM_STRETCH || watchdog_expired) begin
            cnt_r <= '0;
        end else if (cnt_r != STRETCH_LAST) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reset_out_n_r <= 1'b0;
        end else begin
            reset_out_n_r <= (state_nxt == rbm_pkg::RBM_IDLE);
        end
    end

    assign reset_out_n = reset_out_n_r;

    // Boot source caught a fixed lead before release; re-caught if restretched
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            boot_r <= rbm_pkg::RST_BOOT_ROM;
        end else if (state_r == rbm_pkg::RBM_STRETCH && cnt_r == BOOT_AT && !req_any) begin
            boot_r <= boot_select;
        end
    end

    assign boot_from_rom = boot_r;
    assign boot_from_flash = ~boot_r;

    // Only power-on or a write of zero clears it; the reset sequence never touches it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sto_r <= rbm_pkg::RST_STO_LEVEL;
        end else if (sto_we) begin
            sto_r <= sto_level;
        end
    end

    assign soft_turn_off_out = sto_r;

    // Test port routing; reset path is purely combinational
    assign tap_trst_n = alt ? pad_in[rbm_pkg::PIN_IRQ6] : pri_trst_n;
    assign tap_tms = alt ? pad_in[rbm_pkg::PIN_IRQ7] : pri_tms;
    assign tap_tck = alt ? pad_in[rbm_pkg::PIN_KEY_ROW_7] : pri_tck;
    assign tap_tdi = alt ? pad_in[rbm_pkg::PIN_RXD] : pri_tdi;
    assign pri_tdo_out = tap_tdo;
    assign pri_tdo_oe_n = ~(tap_tdo_en & ~alt);

    assign dsp_debug_event = alt ? pad_in[rbm_pkg::PIN_KEY_ROW_6] : 1'b1;
    assign mcu_debug_event = alt ? pad_in[rbm_pkg::PIN_CTS] : 1'b1;
    assign pri_debug_disable = alt;

    assign audio_pri_disable = alt ? '0 : audio_sel;

    // Normal functions see the pads only when the alternate set is off
    assign periph_in = alt ? '0 : pad_in;

    always_comb begin
        pad_out = periph_out;
        pad_oe_n = '1;
        for (int i = 0; i < rbm_pkg::NPINS; i++) begin
            if (!alt && periph_oe[i] && reset_out_n_r) begin
                pad_oe_n[i] = 1'b0;
            end
        end
        if (alt) begin
            pad_out[rbm_pkg::PIN_TXD] = tap_tdo;
            pad_oe_n[rbm_pkg::PIN_TXD] = ~tap_tdo_en;
            pad_out[rbm_pkg::PIN_KEY_ROW_6] = dsp_debug_event_out;
            pad_oe_n[rbm_pkg::PIN_KEY_ROW_6] = ~dsp_debug_event_oe;
            pad_out[rbm_pkg::PIN_CTS] = mcu_debug_event_out;
            pad_oe_n[rbm_pkg::PIN_CTS] = ~mcu_debug_event_oe;
        end
    end

    sequence req_released_s;
        $past(req_any) && !req_any;
    endsequence

    sequence out_low7_s;
        (!reset_out_n_r) [*7];
    endsequence

    out_min_low_a: assert property (@(posedge clk) disable iff (!rstn)
        $fell(reset_out_n_r) |-> out_low7_s)
        else $error("reset output low for fewer than seven cycles");

    req_holds_a: assert property (@(posedge clk) disable iff (!rstn)
        req_any |=> !reset_out_n_r)
        else $error("reset output not active during valid request");

    watchdog_reset_a: assert property (@(posedge clk) disable iff (!rstn)
        watchdog_expired |=> out_low7_s)
        else $error("watchdog expiry did not give a stretched reset");

    stretch_after_a: assert property (@(posedge clk) disable iff (!rstn)
        req_released_s |-> out_low7_s)
        else $error("reset released too soon after request ended");

    alt_request_a: assert property (@(posedge clk) disable iff (!rstn)
        (alt && !pad_in[rbm_pkg::PIN_RTS]) [*6] |=> !reset_out_n_r)
        else $error("alternate request pin did not reset");

    boot_capture_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(reset_out_n_r) |-> boot_r == $past(boot_select, 4))
        else $error("boot mode not taken three cycles before release");

    sto_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        !sto_we |=> $stable(sto_r))
        else $error("soft turn off level changed without a write");

    gpi_default_a: assert property (@(posedge clk) disable iff (!rstn)
        (!reset_out_n_r && !alt) |-> pad_oe_n == '1)
        else $error("muxed pin driven during reset");

    tap_route_a: assert property (@(posedge clk) disable iff (!rstn)
        alt |-> tap_tms == pad_in[rbm_pkg::PIN_IRQ7] && pri_tdo_oe_n && periph_in == '0)
        else $error("primary test port still connected");

    // Release may only follow seven low cycles, whatever started the reset
    sequence out_release_s;
        $rose(reset_out_n_r);
    endsequence

    release_min_a: assert property (@(posedge clk) disable iff (!rstn)
        out_release_s |-> !$past(reset_out_n_r, 7))
        else $error("reset output released before seven low cycles");

    hold_low_a: assert property (@(posedge clk) disable iff (!rstn)
        state_r == rbm_pkg::RBM_HOLD |-> !reset_out_n_r)
        else $error("reset output released while request held");

    stretch_count_a: assert property (@(posedge clk) disable iff (!rstn)
        state_r == rbm_pkg::RBM_STRETCH |-> cnt_r <= STRETCH_LAST)
        else $error("stretch counter ran past its last cycle");

    watch_restart_a: assert property (@(posedge clk) disable iff (!rstn)
        watchdog_expired |=> cnt_r == '0)
        else $error("watchdog expiry did not restart the stretch");

    boot_pair_a: assert property (@(posedge clk) disable iff (!rstn)
        boot_from_flash == !boot_from_rom)
        else $error("boot source outputs disagree");

    boot_steady_a: assert property (@(posedge clk) disable iff (!rstn)
        $changed(boot_r) |-> !reset_out_n_r)
        else $error("boot mode changed outside a reset");

    sto_write_a: assert property (@(posedge clk) disable iff (!rstn)
        sto_we |=> sto_r == $past(sto_level))
        else $error("soft turn off write not taken");

    // Pin routing is static, so it is checked on every cycle
    rts_request_a: assert property (@(posedge clk) disable iff (!rstn)
        alt |-> pri_req_n && alt_req_n == pad_in[rbm_pkg::PIN_RTS])
        else $error("request not taken from the alternate pin");

    tap_normal_a: assert property (@(posedge clk) disable iff (!rstn)
        !alt |-> tap_trst_n == pri_trst_n && tap_tms == pri_tms
            && tap_tck == pri_tck && tap_tdi == pri_tdi)
        else $error("primary test port not connected in normal mode");

    trst_alt_a: assert property (@(posedge clk) disable iff (!rstn)
        alt |-> tap_trst_n == pad_in[rbm_pkg::PIN_IRQ6])
        else $error("alternate test reset not routed");

    alt_swap_a: assert property (@(posedge clk) disable iff (!rstn)
        alt |-> tap_tck == pad_in[rbm_pkg::PIN_KEY_ROW_7] && tap_tdi == pad_in[rbm_pkg::PIN_RXD]
            && pad_out[rbm_pkg::PIN_TXD] == tap_tdo)
        else $error("alternate test pins not swapped in");

    tdo_drive_a: assert property (@(posedge clk) disable iff (!rstn)
        alt |-> pad_oe_n[rbm_pkg::PIN_TXD] == !tap_tdo_en)
        else $error("alternate test data out not driven by the controller");

    alt_inputs_a: assert property (@(posedge clk) disable iff (!rstn)
        alt |-> pad_oe_n[rbm_pkg::PIN_IRQ6] && pad_oe_n[rbm_pkg::PIN_IRQ7]
            && pad_oe_n[rbm_pkg::PIN_KEY_ROW_7] && pad_oe_n[rbm_pkg::PIN_RXD]
            && pad_oe_n[rbm_pkg::PIN_RTS])
        else $error("alternate input pin driven");

    debug_swap_a: assert property (@(posedge clk) disable iff (!rstn)
        alt |-> pri_debug_disable && dsp_debug_event == pad_in[rbm_pkg::PIN_KEY_ROW_6]
            && mcu_debug_event == pad_in[rbm_pkg::PIN_CTS])
        else $error("debug event pins not swapped in");

    audio_route_a: assert property (@(posedge clk) disable iff (!rstn)
        !alt |-> audio_pri_disable == audio_sel)
        else $error("audio primary pin not disabled when muxed");
endmodule
`default_nettype wire

/* tb/rbm_board.sv */
// Board model: reset button, alternate request pin and boot strap
`timescale 1ns/1ps
`default_nettype none
module rbm_board (
    input wire logic clk,
    output logic reset_in_n,
    output logic rts_n,
    output logic boot_select
);
    // Both request pins have pull-ups, so they idle high
    initial begin
        reset_in_n = 1'b1;
        rts_n = 1'b1;
        boot_select = 1'b0;
    end

    // Call just after a rising edge; the pin is low for n sampling edges
    task automatic press(input int n, input logic on_alt, input logic boot);
        boot_select = boot;
        if (on_alt) begin
            rts_n = 1'b0;
        end else begin
            reset_in_n = 1'b0;
        end
        repeat (n) @(posedge clk);
        #1;
        rts_n = 1'b1;
        reset_in_n = 1'b1;
        // Strap moves only after the capture edge, just before release
        repeat (8) @(posedge clk);
        #1;
        boot_select = ~boot;
    endtask

    // Strap set on its own, for resets that no button press starts
    task automatic strap(input logic level);
        boot_select = level;
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the reset, boot and pin selector block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, rstn, watchdog_expired, alt_pin_select, sto_we, sto_level, armed, b;
    logic reset_in_n, rts_n, boot_select, reset_out_n, boot_from_rom, boot_from_flash;
    logic soft_turn_off_out, tap_trst_n, tap_tms, tap_tck, tap_tdi, pri_tdo_out;
    logic pri_tdo_oe_n, dsp_debug_event, mcu_debug_event, pri_debug_disable;
    logic [6:0] pad_lo;
    logic [29:0] rv;
    logic [7:0] pad_out, pad_oe_n, periph_in, p;
    logic [3:0] audio_pri_disable;
    logic [7:0] exp_q[$];
    int fail_count, checked, low_cnt, n;

    rbm_board i_rbm_board (.clk, .reset_in_n, .rts_n, .boot_select);
    rbm_top i_rbm_top (.clk, .rstn, .reset_in_n, .watchdog_expired, .boot_select,
        .alt_pin_select, .reset_out_n, .boot_from_rom, .boot_from_flash, .sto_we,
        .sto_level, .soft_turn_off_out, .pad_in({rts_n, pad_lo}), .pad_out, .pad_oe_n,
        .periph_out(rv[7:0]), .periph_oe(rv[15:8]), .audio_sel(rv[19:16]),
        .periph_in, .audio_pri_disable, .pri_trst_n(rv[20]), .pri_tms(rv[21]),
        .pri_tck(rv[22]), .pri_tdi(rv[23]), .tap_tdo(rv[24]), .tap_tdo_en(rv[25]),
        .tap_trst_n, .tap_tms, .tap_tck, .tap_tdi, .pri_tdo_out, .pri_tdo_oe_n,
        .dsp_debug_event_out(rv[26]), .dsp_debug_event_oe(rv[27]), .mcu_debug_event_out(rv[28]),
        .mcu_debug_event_oe(rv[29]), .dsp_debug_event, .mcu_debug_event, .pri_debug_disable);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    // Negative edge keeps the count clear of the output's own update
    always @(negedge clk) begin
        if (armed && reset_out_n === 1'b0) begin
            low_cnt++;
        end else if (armed && low_cnt > 0) begin
            p = (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00;
            cmp({low_cnt[5:0], boot_from_flash, boot_from_rom}, p);
            low_cnt = 0;
        end
    end

    task automatic check_mux();
        p = {rts_n, pad_lo};
        if (alt_pin_select) begin
            cmp({4'h0, tap_trst_n, tap_tms, tap_tck, tap_tdi},
                {4'h0, p[0], p[1], p[3], p[5]});
            cmp({5'h0, dsp_debug_event, mcu_debug_event, pri_debug_disable},
                {5'h0, p[2], p[6], 1'b1});
            cmp(periph_in, 8'h00);
            cmp({4'h0, audio_pri_disable}, 8'h00);
            cmp(pad_oe_n & 8'hab, 8'hab);
            cmp({6'h0, pad_oe_n[4], pri_tdo_oe_n}, {6'h0, ~rv[25], 1'b1});
            cmp(pad_out & 8'h54, {1'b0, rv[28], 1'b0, rv[24], 1'b0, rv[26], 2'h0});
            cmp({5'h0, pad_oe_n[6], pad_oe_n[2], pri_tdo_out},
                {5'h0, ~rv[29], ~rv[27], rv[24]});
        end else begin
            cmp({4'h0, tap_trst_n, tap_tms, tap_tck, tap_tdi},
                {4'h0, rv[20], rv[21], rv[22], rv[23]});
            cmp(pad_out, rv[7:0]);
            cmp({6'h0, pri_tdo_out, pri_tdo_oe_n}, {6'h0, rv[24], ~rv[25]});
            cmp(periph_in, p);
            cmp({4'h0, audio_pri_disable}, {4'h0, rv[19:16]});
            cmp(pad_oe_n, reset_out_n ? ~rv[15:8] : 8'hff);
            cmp({6'h0, dsp_debug_event, mcu_debug_event}, 8'h03);
        end
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic press_expect(input int len, input logic on_alt, input logic hit);
        b = 1'($urandom);
        if (hit) begin
            // Sync delays both edges alike; the qualifier delays the fall three cycles and the release one
            exp_q.push_back({6'(len + rbm_pkg::STRETCH_CYC + 1 - rbm_pkg::QUAL_CYC), ~b, b});
        end
        i_rbm_board.press(len, on_alt, b);
        repeat (12) tick();
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        {rstn, watchdog_expired, alt_pin_select, sto_we, sto_level, armed} = 6'h00;
        {pad_lo, rv, fail_count, checked, low_cnt} = '0;
        repeat (16) @(posedge clk);
        #1;
        rstn = 1'b1;
        void'($urandom(17123));
        repeat (12) tick();
        armed = 1'b1;
        for (int i = 0; i < 3; i++) begin
            press_expect(8 + int'($urandom % 5), 1'b0, 1'b1);
        end
        press_expect(2, 1'b0, 1'b0);
        press_expect(10, 1'b1, 1'b0);
        $display("test primary request done");
        alt_pin_select = 1'b1;
        press_expect(10, 1'b1, 1'b1);
        press_expect(10, 1'b0, 1'b0);
        alt_pin_select = 1'b0;
        $display("test alternate request done");
        for (int v = 1; v >= 0; v--) begin
            sto_level = 1'(v);
            sto_we = 1'b1;
            tick();
            sto_we = 1'b0;
            rv = 30'($urandom);
            b = 1'($urandom);
            i_rbm_board.strap(b);
            exp_q.push_back({6'(rbm_pkg::STRETCH_CYC), ~b, b});
            watchdog_expired = 1'b1;
            tick();
            watchdog_expired = 1'b0;
            tick();
            check_mux();
            repeat (4) tick();
            i_rbm_board.strap(~b);
            repeat (8) tick();
            cmp({7'h0, soft_turn_off_out}, 8'(v));
        end
        $display("test watchdog done");
        for (int i = 0; i < 8; i++) begin
            alt_pin_select = 1'(i / 4);
            rv = 30'($urandom);
            pad_lo = 7'($urandom);
            #1;
            check_mux();
            tick();
        end
        alt_pin_select = 1'b0;
        $display("test pin routing done");
        repeat (4) tick();
        cmp({7'h0, exp_q.size() == 0}, 8'h01);
        report_and_stop();
    end
endmodule
`default_nettype wire
